// ---- common/dsp_defs.svh ----
/*
 * Shared constants of the diagnostic scan pipeline register.
 * Assumes it is included by bare name wherever the constants are needed.
 */
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH

// Width of the pipeline and shadow registers and of both data ports.
`define DSP_DATA_W      8
// Index of the shadow bit presented on the serial output.
`define DSP_SHADOW_MSB  7
// Index of the shadow bit that takes the serial input on a shift.
`define DSP_SHADOW_LSB  0
// Pipeline and shadow contents after reset.
`define DSP_PIPE_RST    8'h00
`define DSP_SHADOW_RST  8'h00
// Parallel port drive after reset: released, port acts as an input.
`define DSP_DRIVE_RST   1'b0
// Pins after reset: enables high means released.
`define DSP_OE_N_RST    1'b1
`define DSP_SOUT_RST    1'b0
`define DSP_CTL_RST     5'h10

`endif

// ---- common/dsp_pkg.sv ----
/*
 * Types of the diagnostic scan pipeline register.
 * Assumes dsp_defs.svh is on the include path.
 */
`include "dsp_defs.svh"

package dsp_pkg;

  // Control pins, carried together through the synchroniser.
  typedef struct packed {
    logic oe_n;
    logic pclk;
    logic diag_clock;
    logic mode;
    logic scan_in;
  } dsp_ctl_s;

  // Action taken on a diagnostic clock rising edge.
  typedef enum logic [1:0] {
    DSP_DIAG_IDLE,
    DSP_DIAG_SHIFT,
    DSP_DIAG_CAPTURE,
    DSP_DIAG_HOLD
  } dsp_diag_op_e;

endpackage : dsp_pkg

// ---- design/dsp_scan_reg.sv ----
/*
 * Diagnostic scan pipeline register: a pipeline register that drives the
 * output port, and a shadow register that shifts serially, captures the
 * output port or drives the parallel port.
 * Assumes every pin input, both external clocks included, is asynchronous
 * to sys_clk_i and changes no faster than a few sys_clk_i periods; the
 * external clocks are sampled and their rising edges detected here.
 */
`timescale 1ns/1ps
`include "dsp_defs.svh"

// Overview of operation
// - On each pipeline clock rising edge the pipeline register loads from the parallel port or the shadow register as the mode input selects.
// - With mode low at a pipeline clock edge each pipeline bit takes the parallel port bit, which the outside party drives while the port is released.
// - With mode high at a pipeline clock edge each pipeline bit takes the matching shadow bit.
// - With mode low at a diagnostic clock edge the shadow register shifts up, bit 0 taking the serial input.
// - The serial output shows shadow bit 7 while mode is low and follows the serial input while mode is high.
// - With mode high and serial input low at a diagnostic clock edge the shadow register captures the output port pins.
// - With mode high and serial input high at a diagnostic clock edge the shadow register holds and parallel port drive is enabled.
// - When enabled the shadow contents are driven onto the parallel port, and a shift releases the port to act as an input.
// - The pipeline contents drive the output port while its active-low enable is low, and the port is released while it is high.
// - The two clocks act independently, each leaving the other clock's register untouched.
module dsp_scan_reg #(
  parameter int W = `DSP_DATA_W
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         pipe_clock_i,
  input  wire logic         diag_clock_i,
  input  wire logic         mode_i,
  input  wire logic         scan_in_i,
  input  wire logic         output_port_enable_n_i,
  input  wire logic [W-1:0] par_i,
  output logic      [W-1:0] par_o,
  output logic              par_oe_n_o,
  input  wire logic [W-1:0] out_port_i,
  output logic      [W-1:0] out_port_o,
  output logic              out_port_oe_n_o,
  output logic              scan_out_o
);

  // Rising edge between two consecutive synchronised samples.
  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction : rise

  // Action of a diagnostic edge: mode low shifts, while mode high captures
  // the output port with the serial input low and holds with it high.
  function automatic dsp_pkg::dsp_diag_op_e diag_decode(
    input logic edge_seen,
    input logic mode_lvl,
    input logic sin_lvl
  );
    if (!edge_seen) begin
      diag_decode = dsp_pkg::DSP_DIAG_IDLE;
    end else if (!mode_lvl) begin
      diag_decode = dsp_pkg::DSP_DIAG_SHIFT;
    end else if (!sin_lvl) begin
      diag_decode = dsp_pkg::DSP_DIAG_CAPTURE;
    end else begin
      diag_decode = dsp_pkg::DSP_DIAG_HOLD;
    end
  endfunction : diag_decode

  // One shift step: every bit moves up one place and bit 0 takes the
  // serial input, so the first bit shifted in is the first to leave.
  function automatic logic [W-1:0] shift_up(
    input logic [W-1:0] cur,
    input logic         sin_lvl
  );
    shift_up = {cur[W-2:`DSP_SHADOW_LSB], sin_lvl};
  endfunction : shift_up

  // Pipeline source: the shadow register with mode high, else the port.
  function automatic logic [W-1:0] pipe_select(
    input logic         mode_lvl,
    input logic [W-1:0] shadow_val,
    input logic [W-1:0] port_val
  );
    pipe_select = mode_lvl ? shadow_val : port_val;
  endfunction : pipe_select

  // Serial output source: the serial input passes through with mode high,
  // otherwise the top shadow bit is shown.
  function automatic logic sout_select(
    input logic mode_lvl,
    input logic sin_lvl,
    input logic top_bit
  );
    sout_select = mode_lvl ? sin_lvl : top_bit;
  endfunction : sout_select

  dsp_pkg::dsp_ctl_s ctl_pins;
  dsp_pkg::dsp_ctl_s ctl_meta_reg;
  dsp_pkg::dsp_ctl_s ctl_sync_reg;
  logic              pclk_prev_reg;
  logic              diag_clock_prev_reg;
  logic [W-1:0]      par_meta_reg;
  logic [W-1:0]      par_sync_reg;
  logic [W-1:0]      outp_meta_reg;
  logic [W-1:0]      outp_sync_reg;

  logic [W-1:0]      pipe_reg;
  logic [W-1:0]      pipe_next;
  logic [W-1:0]      shadow_reg;
  logic [W-1:0]      shadow_next;
  logic              drive_reg;
  logic              drive_next;
  logic              par_oe_n_reg;
  logic              out_oe_n_reg;
  logic              scan_out_reg;
  logic              scan_out_next;

  assign ctl_pins = '{oe_n:    output_port_enable_n_i,
                      pclk:    pipe_clock_i,
                      diag_clock:    diag_clock_i,
                      mode:    mode_i,
                      scan_in: scan_in_i};

  // Control and data pass the same two stages, so the mode, serial input and
  // port levels seen at a detected clock edge are those of that edge. Only
  // the second stage of each pair reads the first.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_meta_reg <= `DSP_CTL_RST;
    end else begin
      ctl_meta_reg <= ctl_pins;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_sync_reg <= `DSP_CTL_RST;
    end else begin
      ctl_sync_reg <= ctl_meta_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_meta_reg <= '0;
    end else begin
      par_meta_reg <= par_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_sync_reg <= '0;
    end else begin
      par_sync_reg <= par_meta_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      outp_meta_reg <= '0;
    end else begin
      outp_meta_reg <= out_port_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      outp_sync_reg <= '0;
    end else begin
      outp_sync_reg <= outp_meta_reg;
    end
  end

  // Last synchronised level of each external clock. Reset matches the idle
  // low level of both clocks, so no false edge follows reset.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pclk_prev_reg <= 1'b0;
    end else begin
      pclk_prev_reg <= ctl_sync_reg.pclk;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_clock_prev_reg <= 1'b0;
    end else begin
      diag_clock_prev_reg <= ctl_sync_reg.diag_clock;
    end
  end

  wire logic pclk_s    = ctl_sync_reg.pclk;
  wire logic diag_clock_s    = ctl_sync_reg.diag_clock;
  wire logic pclk_rise = rise(pclk_prev_reg, pclk_s);
  wire logic diag_clock_rise = rise(diag_clock_prev_reg, diag_clock_s);
  wire logic mode_s    = ctl_sync_reg.mode;
  wire logic sin_s     = ctl_sync_reg.scan_in;
  wire logic oe_n_s    = ctl_sync_reg.oe_n;

  // Pipeline source follows the mode level at the pipeline edge.
  wire logic [W-1:0] pipe_src = pipe_select(mode_s,
                                            shadow_reg,
                                            par_sync_reg);

  // Only a pipeline edge touches the pipeline register.
  assign pipe_next = pclk_rise ? pipe_src : pipe_reg;

  dsp_pkg::dsp_diag_op_e diag_op;
  assign diag_op = diag_decode(diag_clock_rise, mode_s, sin_s);

  wire logic [W-1:0] shadow_shift = shift_up(shadow_reg, sin_s);

  // Only a diagnostic edge touches the shadow register and the drive state.
  always_comb begin
    shadow_next = shadow_reg;
    drive_next  = drive_reg;
    case (diag_op)
      // A shift also drops the parallel drive, turning the port into an input.
      dsp_pkg::DSP_DIAG_SHIFT: begin
        shadow_next = shadow_shift;
        drive_next  = 1'b0;
      end
      // A capture leaves the drive state as it was.
      dsp_pkg::DSP_DIAG_CAPTURE: begin
        shadow_next = outp_sync_reg;
      end
      // A hold keeps the contents and turns the parallel drive on.
      dsp_pkg::DSP_DIAG_HOLD: begin
        drive_next = 1'b1;
      end
      // No diagnostic edge: the shadow register and drive state stay.
      default: begin
        shadow_next = shadow_reg;
      end
    endcase
  end

  // Serial output is registered, so it trails the pins by the sync delay.
  assign scan_out_next = sout_select(mode_s, sin_s,
                                     shadow_next[`DSP_SHADOW_MSB]);

  // Reset stands in for the undefined power-up contents.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe_reg <= `DSP_PIPE_RST;
    end else begin
      pipe_reg <= pipe_next;
    end
  end

  // The shadow register moves only on diagnostic edges.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shadow_reg <= `DSP_SHADOW_RST;
    end else begin
      shadow_reg <= shadow_next;
    end
  end

  // The drive state outlives captures; only shifts and holds change it.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_reg <= `DSP_DRIVE_RST;
    end else begin
      drive_reg <= drive_next;
    end
  end

  // Both enables are active low and come out of reset released.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_oe_n_reg <= `DSP_OE_N_RST;
    end else begin
      par_oe_n_reg <= ~drive_next;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_oe_n_reg <= `DSP_OE_N_RST;
    end else begin
      out_oe_n_reg <= oe_n_s;
    end
  end

  // The serial output trails its pins by the synchroniser delay.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_out_reg <= `DSP_SOUT_RST;
    end else begin
      scan_out_reg <= scan_out_next;
    end
  end

  // Every output comes straight from a register.
  assign par_o           = shadow_reg;
  assign par_oe_n_o      = par_oe_n_reg;
  assign out_port_o      = pipe_reg;
  assign out_port_oe_n_o = out_oe_n_reg;
  assign scan_out_o      = scan_out_reg;

endmodule : dsp_scan_reg

// ---- testbench/dsp_far_end.sv ----
/* Datapath and output-port load seen by the scan register.
   Assumes it drives each pin only while the device has released it. */
`timescale 1ns/1ps
module dsp_far_end (
  input  wire logic [7:0] dd_i,
  input  wire logic       dd_oe_n_i,
  input  wire logic [7:0] yd_i,
  input  wire logic       yd_oe_n_i,
  input  wire logic [7:0] dp_i,
  input  wire logic [7:0] ey_i,
  output logic      [7:0] d_wire_o,
  output logic      [7:0] y_wire_o
);
  assign d_wire_o = dd_oe_n_i ? dp_i : dd_i;
  assign y_wire_o = yd_oe_n_i ? ey_i : yd_i;
endmodule : dsp_far_end

// ---- testbench/dsp_scan_reg_sva.sv ----
/* Port checker for the scan register, bound onto the design module.
   Assumes each external clock phase lasts at least four sys_clk cycles. */
`timescale 1ns/1ps
module dsp_scan_reg_sva #(
  parameter int W = 8
) (
  input wire logic         sys_clk_i,
  input wire logic         rst_n_i,
  input wire logic         pipe_clock_i,
  input wire logic         diag_clock_i,
  input wire logic         mode_i,
  input wire logic         scan_in_i,
  input wire logic         output_port_enable_n_i,
  input wire logic [W-1:0] par_i,
  input wire logic [W-1:0] par_o,
  input wire logic         par_oe_n_o,
  input wire logic [W-1:0] out_port_i,
  input wire logic [W-1:0] out_port_o,
  input wire logic         out_port_oe_n_o,
  input wire logic         scan_out_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_shift_op: assert property (
    $rose(diag_clock_i) && !mode_i |-> ##4 par_oe_n_o &&
    par_o == {$past(par_o[W-2:0], 3), $past(scan_in_i, 4)})
    else $error("shift result wrong");
  a_capture_op: assert property (
    $rose(diag_clock_i) && mode_i && !scan_in_i
    |-> ##4 par_o == $past(out_port_i, 4))
    else $error("capture wrong");
  a_hold_drive: assert property (
    $rose(diag_clock_i) && mode_i && scan_in_i
    |-> ##4 !par_oe_n_o && par_o == $past(par_o, 4))
    else $error("hold wrong");
  a_pipe_shadow: assert property (
    $rose(pipe_clock_i) && mode_i |-> ##4 out_port_o == par_o)
    else $error("pipeline from shadow wrong");
  a_pipe_port: assert property (
    $rose(pipe_clock_i) && !mode_i |-> ##4 out_port_o == $past(par_i, 4))
    else $error("pipeline load wrong");
  a_sout_bypass: assert property (
    (mode_i && scan_in_i)[*5] |-> scan_out_o)
    else $error("serial output not following input");
  a_sout_shadow: assert property (
    !$past(mode_i, 3) |-> scan_out_o == par_o[W-1])
    else $error("serial output not showing top shadow bit");
  a_oe_follow: assert property (
    $stable(output_port_enable_n_i)[*5]
    |-> out_port_oe_n_o == output_port_enable_n_i)
    else $error("oe wrong");
  a_drive_kept: assert property (
    $changed(par_oe_n_o) |-> $past(diag_clock_i, 2))
    else $error("drive changed without edge");
  a_shadow_quiet: assert property (
    $changed(par_o) |-> $past(diag_clock_i, 2))
    else $error("shadow changed without diagnostic edge");
  c_shift: cover property ($rose(diag_clock_i) && !mode_i);
  c_hold: cover property ($rose(diag_clock_i) && mode_i && scan_in_i);
  c_pipe: cover property ($rose(pipe_clock_i) && mode_i);
endmodule : dsp_scan_reg_sva

bind dsp_scan_reg dsp_scan_reg_sva #(.W(W)) i_dsp_scan_reg_sva (.*);

// ---- testbench/dsp_scan_reg_tb.sv ----
/* Self-checking bench for the scan register.
   Assumes the checker is bound and the far end model is compiled. */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  err_count++; $display("ERROR %0t mismatch", $time); end end
module dsp_scan_reg_tb;
  logic       sys_clk_i = 0, rst_n_i = 0, pipe_clock_i = 0, diag_clock_i = 0;
  logic       mode_i = 0, scan_in_i = 0, output_port_enable_n_i = 1;
  logic [7:0] par_i, par_o, out_port_i, out_port_o, dp = 8'h00, ey = 8'h00;
  logic       par_oe_n_o, out_port_oe_n_o, scan_out_o;
  int         err_count = 0, num_checks = 0, cyc = 0;
  localparam logic [7:0] PAT = 8'ha5;
  dsp_scan_reg i_dsp_scan_reg (.*);
  dsp_far_end i_dsp_far_end (.dd_i(par_o), .dd_oe_n_i(par_oe_n_o),
    .yd_i(out_port_o), .yd_oe_n_i(out_port_oe_n_o), .dp_i(dp), .ey_i(ey),
    .d_wire_o(par_i), .y_wire_o(out_port_i));
  initial forever #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end
  // Mode and serial input settle three cycles before the edge; each pulse
  // spans one 400 ns period of the diagnostic or pipeline clock.
  task automatic pulse(input bit d, input bit m, input bit s);
    mode_i <= m;
    scan_in_i <= s;
    repeat (3) @(posedge sys_clk_i);
    if (d) diag_clock_i <= 1'b1;
    else pipe_clock_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    diag_clock_i <= 1'b0;
    pipe_clock_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : pulse
  task automatic t_shift_hold;
    for (int i = 7; i >= 0; i--) pulse(1'b1, 1'b0, PAT[i]);
    `CHK(par_o, PAT)
    `CHK(scan_out_o, PAT[7])
    pulse(1'b1, 1'b1, 1'b1);
    `CHK(par_oe_n_o, 1'b0)
    `CHK(par_i, PAT)
    `CHK(scan_out_o, 1'b1)
  endtask : t_shift_hold
  task automatic t_pipe_capture;
    output_port_enable_n_i <= 1'b0;
    pulse(1'b0, 1'b1, 1'b0);
    `CHK(out_port_o, PAT)
    `CHK(out_port_oe_n_o, 1'b0)
    `CHK(par_o, PAT)
    output_port_enable_n_i <= 1'b1;
    ey <= 8'h3c;
    pulse(1'b1, 1'b1, 1'b0);
    `CHK(par_o, 8'h3c)
    `CHK(par_oe_n_o, 1'b0)
    `CHK(scan_out_o, 1'b0)
    `CHK(out_port_o, PAT)
  endtask : t_pipe_capture
  task automatic t_release_load;
    pulse(1'b1, 1'b0, 1'b1);
    `CHK(par_oe_n_o, 1'b1)
    `CHK(par_o, 8'h79)
    `CHK(scan_out_o, 1'b0)
    dp <= 8'hc3;
    pulse(1'b0, 1'b0, 1'b0);
    `CHK(out_port_o, 8'hc3)
    `CHK(out_port_oe_n_o, 1'b1)
  endtask : t_release_load
  task automatic finish_test;
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_shift_hold();
    t_pipe_capture();
    t_release_load();
    finish_test();
  end
endmodule : dsp_scan_reg_tb
